// ---- hdl/sms_scan_mode_selector.v ----
`timescale 1ns/100ps
`default_nettype none
`include "sms_map.vh"

// Behaviour
// (R1) Slave mode must share the master's output line-scanning pattern; mismatch is flagged.
// (R2) Interlaced slave codes: median, frame rep, AABB, AAAA I/II, BBBB I/II; 111 undefined.
// (R3) Progressive slave codes: median, frame rep, doubling, intra-field; 110 undefined.
// (R4) Software uses median/frame-rep only in config 00, intra-field only in 01.
// (R5) Slave code 010 gives pair pattern, 100/110 constant, others alternate; progressive alpha+beta.
// (R6) Lines per field follow the pattern: 312/313, 312.5, or the pair sequence.
// (R7) Adaptive 000/001 passes the programmed master and slave modes unchanged.
// (R8) With the vcr master bit set the nonstandard-sequence flag is held at zero.
// (R9) Adaptive 010..111 with nonstandard sequence force master 0101, slave 010.
// (R10) Adaptive 010 passes programmed modes when the sequence flag is clear.
// (R11) Adaptive 011 forces master 0011 without global motion.
// (R12) Adaptive 100 picks PAL or NTSC film code by type and phase when film detected.
// (R13) Adaptive 101: no motion gives 0011, else behaves as adaptive 100.
// (R14) Adaptive 110 ignores film type; detected film picks PAL code by phase.
// (R15) Adaptive 111: no motion gives 0011, else behaves as adaptive 110.
// (R16) Global motion, film type, film detected and phase flags are readable by software.
// (R17) Master, adaptive and slave fields sit at offsets 48h, 49h and 4Ah.
// (R18) Effective modes are updated only at output field boundaries.

module sms_scan_mode_selector (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire field_start,
  input wire global_motion_flag,
  input wire film_type_flag,
  input wire film_detected_flag,
  input wire film_phase_flag,
  input wire sync_nonstandard,
  output reg [3:0] effective_master_q,
  output reg [2:0] effective_slave_q,
  output reg [1:0] line_pattern_q,
  output reg [9:0] output_half_lines_q,
  output reg slave_mode_error_q
);

  // ****************************************************************
  // Software-written fields and internal state.
  // ****************************************************************
  reg [3:0] master_static_mode_q;
  reg [2:0] adaptive_mode_select_q;
  reg [2:0] slave_static_mode_q;
  reg progressive_select_q;
  reg [1:0] memory_configuration_q;
  reg vcr_mode_master_bit_q;
  reg [1:0] field_phase_q;
  reg [1:0] pattern_d;
  reg pattern_swap_d;
  reg pattern_swap_q;
  reg slave_ok_d;
  reg [9:0] half_lines_d;
  reg [31:0] rdata_d;
  reg aw_held_q;
  reg w_held_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire nonstandard_sequence_flag;
  wire [3:0] effective_master_mode;
  wire [2:0] effective_slave_mode;

  assign nonstandard_sequence_flag = sync_nonstandard & ~vcr_mode_master_bit_q; // [R8]

  sms_mode_logic u_mode (
    .master_static_mode(master_static_mode_q),
    .slave_static_mode(slave_static_mode_q),
    .adaptive_mode_select(adaptive_mode_select_q),
    .global_motion_flag(global_motion_flag),
    .film_type_flag(film_type_flag),
    .film_detected_flag(film_detected_flag),
    .film_phase_flag(film_phase_flag),
    .nonstandard_sequence_flag(nonstandard_sequence_flag),
    .effective_master_mode(effective_master_mode),
    .effective_slave_mode(effective_slave_mode)
  );

  // ****************************************************************
  // Pattern class of a slave code.
  // ****************************************************************
  function [1:0] slave_pattern;
    input prog;
    input [2:0] code;
    begin
      if (prog) begin
        slave_pattern = `SMS_PAT_PROG; // [R5]
      end else if (code == `SMS_S_SIMPLE) begin
        slave_pattern = `SMS_PAT_PAIR; // [R5]
      end else if (code == `SMS_S_AAAA2 || code == `SMS_S_BBBB2) begin
        slave_pattern = `SMS_PAT_CONST; // [R5]
      end else begin
        slave_pattern = `SMS_PAT_ALT; // [R5]
      end
    end
  endfunction

  // ****************************************************************
  // Slave legality: pattern, defined code, memory configuration.
  // ****************************************************************
  always @* begin
    pattern_d = slave_pattern(progressive_select_q, effective_slave_mode);
    // Only the constant BBBB II code starts on the beta field; the others start on alpha.
    pattern_swap_d = !progressive_select_q && effective_slave_mode == `SMS_S_BBBB2; // [R6]
    slave_ok_d = 1'b1;
    if (!progressive_select_q) begin
      if (effective_slave_mode == `SMS_S_UNDEF_I) begin
        slave_ok_d = 1'b0; // [R2]
      end
      if (effective_slave_mode <= 3'h1 && memory_configuration_q != 2'h0) begin
        slave_ok_d = 1'b0; // [R4]
      end
      // Simple field mode of the master pairs only with the AABB slave.
      if ((effective_master_mode == `SMS_M_SIMPLE) != (pattern_d == `SMS_PAT_PAIR)) begin
        slave_ok_d = 1'b0; // [R1]
      end
    end else begin
      if (effective_slave_mode == `SMS_S_UNDEF_P) begin
        slave_ok_d = 1'b0; // [R3]
      end
      if (effective_slave_mode <= 3'h1 && memory_configuration_q != 2'h0) begin
        slave_ok_d = 1'b0; // [R4]
      end
      if ((effective_slave_mode == 3'h4 || effective_slave_mode == 3'h7) &&
          memory_configuration_q != 2'h1) begin
        slave_ok_d = 1'b0; // [R4]
      end
    end
  end

  // ****************************************************************
  // Half lines to the next vertical sync.
  // ****************************************************************
  always @* begin
    half_lines_d = `SMS_HL_HALF;
    case (line_pattern_q)
      `SMS_PAT_CONST: begin
        half_lines_d = (field_phase_q[0] ^ pattern_swap_q) ? `SMS_HL_LONG : `SMS_HL_SHORT; // [R6]
      end
      `SMS_PAT_PAIR: begin
        if (field_phase_q[0]) begin
          half_lines_d = `SMS_HL_HALF; // [R6]
        end else begin
          half_lines_d = (field_phase_q[1] ^ pattern_swap_q) ? `SMS_HL_LONG : `SMS_HL_SHORT;
        end
      end
      default: begin
        half_lines_d = `SMS_HL_HALF; // [R6]
      end
    endcase
  end

  // ****************************************************************
  // Field-boundary update.
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      effective_master_q <= `SMS_RST_MASTER;
      effective_slave_q <= `SMS_RST_SLAVE;
      line_pattern_q <= `SMS_PAT_ALT;
      pattern_swap_q <= 1'b0;
      field_phase_q <= 2'h0;
      output_half_lines_q <= `SMS_HL_HALF;
      slave_mode_error_q <= 1'b0;
    end else if (field_start) begin
      // Switching mid-field would tear the picture, so changes wait here.
      effective_master_q <= effective_master_mode; // [R18]
      effective_slave_q <= effective_slave_mode; // [R18]
      line_pattern_q <= pattern_d;
      pattern_swap_q <= pattern_swap_d;
      field_phase_q <= field_phase_q + 2'h1;
      output_half_lines_q <= half_lines_d; // [R6]
      slave_mode_error_q <= ~slave_ok_d; // [R1]
    end
  end

  // ****************************************************************
  // AXI4-Lite write path.
  // ****************************************************************

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      master_static_mode_q <= `SMS_RST_MASTER;
      adaptive_mode_select_q <= `SMS_RST_ADAPT;
      slave_static_mode_q <= `SMS_RST_SLAVE;
      progressive_select_q <= 1'b0;
      memory_configuration_q <= 2'h0;
      vcr_mode_master_bit_q <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !aw_held_q && !s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && !w_held_q && !s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b1;
      end
      if (aw_held_q && w_held_q && !s_axi_bvalid) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (wstrb_q[0]) begin
          case (awaddr_q)
            `SMS_OFF_MASTER: master_static_mode_q <= wdata_q[3:0]; // [R17]
            `SMS_OFF_ADAPT: adaptive_mode_select_q <= wdata_q[2:0]; // [R17]
            `SMS_OFF_SLAVE: slave_static_mode_q <= wdata_q[2:0]; // [R17]
            `SMS_OFF_CTRL: begin
              progressive_select_q <= wdata_q[`SMS_CTRL_PROG];
              memory_configuration_q <= wdata_q[`SMS_CTRL_MEMHI:`SMS_CTRL_MEMLO];
              vcr_mode_master_bit_q <= wdata_q[`SMS_CTRL_VCR];
            end
            `SMS_OFF_FLAGS, `SMS_OFF_EFF: s_axi_bresp <= 2'h0;
            default: s_axi_bresp <= 2'h2;
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read path.
  // ****************************************************************
  always @* begin
    rdata_d = 32'h00000000;
    case (s_axi_araddr)
      `SMS_OFF_MASTER: rdata_d[3:0] = master_static_mode_q;
      `SMS_OFF_ADAPT: rdata_d[2:0] = adaptive_mode_select_q;
      `SMS_OFF_SLAVE: rdata_d[2:0] = slave_static_mode_q;
      `SMS_OFF_CTRL: begin
        rdata_d[`SMS_CTRL_PROG] = progressive_select_q;
        rdata_d[`SMS_CTRL_MEMHI:`SMS_CTRL_MEMLO] = memory_configuration_q;
        rdata_d[`SMS_CTRL_VCR] = vcr_mode_master_bit_q;
      end
      `SMS_OFF_FLAGS: begin
        rdata_d[`SMS_FLG_GMOT] = global_motion_flag; // [R16]
        rdata_d[`SMS_FLG_FTYP] = film_type_flag; // [R16]
        rdata_d[`SMS_FLG_FDET] = film_detected_flag; // [R16]
        rdata_d[`SMS_FLG_FPH] = film_phase_flag; // [R16]
        rdata_d[`SMS_FLG_NSEQ] = nonstandard_sequence_flag;
      end
      `SMS_OFF_EFF: begin
        rdata_d[3:0] = effective_master_q;
        rdata_d[`SMS_EFF_SLV_LO+2:`SMS_EFF_SLV_LO] = effective_slave_q;
        rdata_d[`SMS_EFF_PAT_LO+1:`SMS_EFF_PAT_LO] = line_pattern_q;
        rdata_d[`SMS_EFF_PAT_LO+2] = slave_mode_error_q;
        rdata_d[`SMS_EFF_LPF_LO+9:`SMS_EFF_LPF_LO] = output_half_lines_q;
      end
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= (s_axi_araddr == `SMS_OFF_MASTER || s_axi_araddr == `SMS_OFF_ADAPT ||
                        s_axi_araddr == `SMS_OFF_SLAVE || s_axi_araddr == `SMS_OFF_CTRL ||
                        s_axi_araddr == `SMS_OFF_FLAGS || s_axi_araddr == `SMS_OFF_EFF) ?
                       2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // sms_scan_mode_selector

`default_nettype wire

// ---- include/sms_map.vh ----
`ifndef SMS_MAP_VH
`define SMS_MAP_VH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define SMS_OFF_MASTER 8'h48
`define SMS_OFF_ADAPT 8'h49
`define SMS_OFF_SLAVE 8'h4A
`define SMS_OFF_CTRL 8'h50
`define SMS_OFF_FLAGS 8'h54
`define SMS_OFF_EFF 8'h58

// ****************************************************************
// Field positions in the control, flag and effective registers.
// ****************************************************************
`define SMS_CTRL_PROG 0
`define SMS_CTRL_MEMLO 1
`define SMS_CTRL_MEMHI 2
`define SMS_CTRL_VCR 3
`define SMS_FLG_GMOT 0
`define SMS_FLG_FTYP 1
`define SMS_FLG_FDET 2
`define SMS_FLG_FPH 3
`define SMS_FLG_NSEQ 4
`define SMS_EFF_SLV_LO 4
`define SMS_EFF_PAT_LO 8
`define SMS_EFF_LPF_LO 12

// ****************************************************************
// Reset values.
// ****************************************************************
`define SMS_RST_MASTER 4'h0
`define SMS_RST_ADAPT 3'h0
`define SMS_RST_SLAVE 3'h0
`define SMS_RST_CTRL 4'h0

// ****************************************************************
// Mode codes.
// ****************************************************************
`define SMS_M_PAL0 4'h1
`define SMS_M_PAL1 4'h2
`define SMS_M_FRAMEREP 4'h3
`define SMS_M_SIMPLE 4'h5
`define SMS_M_NTSC0 4'hE
`define SMS_M_NTSC1 4'hF
`define SMS_S_SIMPLE 3'h2
`define SMS_S_AAAA2 3'h4
`define SMS_S_BBBB2 3'h6
`define SMS_S_UNDEF_I 3'h7
`define SMS_S_UNDEF_P 3'h6
`define SMS_A_PASS 3'h2
`define SMS_A_STILL 3'h3
`define SMS_A_FILM1 3'h4
`define SMS_A_FILM2 3'h5
`define SMS_A_FILM3 3'h6
`define SMS_A_FILM4 3'h7

// ****************************************************************
// Line-scanning pattern classes.
// ****************************************************************
`define SMS_PAT_ALT 2'h0
`define SMS_PAT_PAIR 2'h1
`define SMS_PAT_CONST 2'h2
`define SMS_PAT_PROG 2'h3

// ****************************************************************
// Half-line counts between output vertical syncs.
// ****************************************************************
`define SMS_HL_SHORT 10'h270
`define SMS_HL_HALF 10'h271
`define SMS_HL_LONG 10'h272

`endif

// ---- hdl/sms_mode_logic.v ----
`timescale 1ns/100ps
`default_nettype none
`include "sms_map.vh"

module sms_mode_logic (
  input wire [3:0] master_static_mode,
  input wire [2:0] slave_static_mode,
  input wire [2:0] adaptive_mode_select,
  input wire global_motion_flag,
  input wire film_type_flag,
  input wire film_detected_flag,
  input wire film_phase_flag,
  input wire nonstandard_sequence_flag,
  output reg [3:0] effective_master_mode,
  output reg [2:0] effective_slave_mode
);

  // ****************************************************************
  // Film master code from type and phase.
  // ****************************************************************
  function [3:0] film_code;
    input ntsc;
    input phase;
    begin
      if (ntsc) begin
        film_code = phase ? `SMS_M_NTSC1 : `SMS_M_NTSC0;
      end else begin
        film_code = phase ? `SMS_M_PAL1 : `SMS_M_PAL0;
      end
    end
  endfunction

  always @* begin
    effective_master_mode = master_static_mode; // [R7]
    effective_slave_mode = slave_static_mode; // [R7]
    case (adaptive_mode_select)
      `SMS_A_PASS: begin
        effective_master_mode = master_static_mode; // [R10]
      end
      `SMS_A_STILL: begin
        if (!global_motion_flag) begin
          effective_master_mode = `SMS_M_FRAMEREP; // [R11]
        end
      end
      `SMS_A_FILM1: begin
        if (film_detected_flag) begin
          effective_master_mode = film_code(film_type_flag, film_phase_flag); // [R12]
        end
      end
      `SMS_A_FILM2: begin
        if (!global_motion_flag) begin
          effective_master_mode = `SMS_M_FRAMEREP; // [R13]
        end else if (film_detected_flag) begin
          effective_master_mode = film_code(film_type_flag, film_phase_flag); // [R13]
        end
      end
      `SMS_A_FILM3: begin
        if (film_detected_flag) begin
          effective_master_mode = film_code(1'b0, film_phase_flag); // [R14]
        end
      end
      `SMS_A_FILM4: begin
        if (!global_motion_flag) begin
          effective_master_mode = `SMS_M_FRAMEREP; // [R15]
        end else if (film_detected_flag) begin
          effective_master_mode = film_code(1'b0, film_phase_flag); // [R15]
        end
      end
      default: begin
        effective_master_mode = master_static_mode; // [R7]
      end
    endcase
    // The sequence override sits last so it beats every other condition.
    if (adaptive_mode_select >= `SMS_A_PASS && nonstandard_sequence_flag) begin
      effective_master_mode = `SMS_M_SIMPLE; // [R9]
      effective_slave_mode = `SMS_S_SIMPLE; // [R9]
    end
  end

endmodule // sms_mode_logic

`default_nettype wire

// ---- verif/sms_scan_mode_selector_props.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sms_map.vh"

module sms_scan_mode_selector_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic field_start,
  input wire logic [3:0] effective_master_q,
  input wire logic [2:0] effective_slave_q,
  input wire logic [1:0] line_pattern_q,
  input wire logic [9:0] output_half_lines_q,
  input wire logic slave_mode_error_q
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // A mode switch inside a field would tear the picture, so modes, pattern and error flag hold between boundaries.
  property p_hold_modes;
    !field_start |=> $stable(effective_master_q) && $stable(effective_slave_q);
  endproperty
  a_hold_modes: assert property (p_hold_modes)
    else $error("Effective modes changed inside a field.");
  property p_hold_class;
    !field_start |=> $stable(line_pattern_q) && $stable(slave_mode_error_q);
  endproperty
  a_hold_class: assert property (p_hold_class)
    else $error("Pattern or error flag changed inside a field.");
  property p_pair_slave;
    line_pattern_q == `SMS_PAT_PAIR |-> effective_slave_q == `SMS_S_SIMPLE;
  endproperty
  a_pair_slave: assert property (p_pair_slave)
    else $error("Pair pattern without the simple slave code.");
  property p_const_slave;
    line_pattern_q == `SMS_PAT_CONST |->
      effective_slave_q inside {`SMS_S_AAAA2, `SMS_S_BBBB2};
  endproperty
  a_const_slave: assert property (p_const_slave)
    else $error("Constant pattern from a wrong slave code.");
  property p_alt_lines;
    field_start && line_pattern_q == `SMS_PAT_ALT |=> output_half_lines_q == `SMS_HL_HALF;
  endproperty
  a_alt_lines: assert property (p_alt_lines)
    else $error("Alternating pattern gave a wrong line count.");
  property p_const_lines;
    field_start && line_pattern_q == `SMS_PAT_CONST |=>
      output_half_lines_q inside {`SMS_HL_SHORT, `SMS_HL_LONG};
  endproperty
  a_const_lines: assert property (p_const_lines)
    else $error("Constant pattern gave a half line count.");
  property p_mismatch;
    line_pattern_q != `SMS_PAT_PROG &&
      ((effective_master_q == `SMS_M_SIMPLE) != (effective_slave_q == `SMS_S_SIMPLE))
      |-> slave_mode_error_q;
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("Master and slave patterns differ without an error.");
  property p_write_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("Write response late.");
  property p_read_resp;
    s_axi_arvalid && s_axi_arready |-> s_axi_rvalid;
  endproperty
  a_read_resp: assert property (p_read_resp)
    else $error("Read data not offered with the address accept.");
endmodule // sms_scan_mode_selector_chk

`default_nettype wire

// ---- verif/sms_scan_mode_selector_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sms_map.vh"

module sms_scan_mode_selector_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, field_start, global_motion_flag, film_type_flag;
  logic film_detected_flag, film_phase_flag, sync_nonstandard, slave_mode_error_q;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, effective_master_q, m, ctrl;
  logic [1:0] s_axi_bresp, s_axi_rresp, line_pattern_q, rr;
  logic [2:0] effective_slave_q, s, a, ad;
  logic [9:0] output_half_lines_q;
  logic [9:0] h[4];
  logic [4:0] f;
  logic [6:0] e;
  logic [15:0] rnd;
  int failures, cmp_count, cyc;

  sms_scan_mode_selector u_sms_scan_mode_selector (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      complete_run;
    end
  end

  // ****************************************
  // Bus cycles, checks and reference model
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic axw(input logic [7:0] ad8, input logic [31:0] d, input logic [3:0] st);
    s_axi_awaddr <= ad8;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axr(input logic [7:0] ad8);
    s_axi_araddr <= ad8;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic field;
    field_start <= 1'b1;
    @(posedge aclk);
    field_start <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic lines(input logic [3:0] mm, input logic [2:0] ss);
    axw(`SMS_OFF_MASTER, {28'h0, mm}, 4'hF);
    axw(`SMS_OFF_SLAVE, {29'h0, ss}, 4'hF);
    field;
    foreach (h[i]) begin
      field;
      h[i] = output_half_lines_q;
    end
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Flags are packed as nonstandard, phase, detected, type, motion.
  function automatic logic [6:0] eff(input logic [3:0] mm, input logic [2:0] ss, aa,
                                     input logic [4:0] ff);
    if (aa < 3'h2) return {mm, ss};
    if (ff[4]) return {`SMS_M_SIMPLE, `SMS_S_SIMPLE};
    if (aa[0] && !ff[0]) return {`SMS_M_FRAMEREP, ss};
    if (aa[2] && ff[2]) return {(ff[1] && !aa[1]) ? {3'h7, ff[3]} : {2'h0, ff[3], !ff[3]}, ss};
    return {mm, ss};
  endfunction

  function automatic logic [1:0] pat(input logic p, input logic [2:0] ss);
    if (p) return `SMS_PAT_PROG;
    if (ss == 3'h2) return `SMS_PAT_PAIR;
    if (ss == 3'h4 || ss == 3'h6) return `SMS_PAT_CONST;
    return `SMS_PAT_ALT;
  endfunction

  function automatic logic err(input logic p, input logic [1:0] mem, input logic [3:0] mm,
                               input logic [2:0] ss);
    if (ss == (p ? 3'h6 : 3'h7)) return 1'b1;
    if (ss < 3'h2 && mem != 2'h0) return 1'b1;
    if (p && (ss == 3'h4 || ss == 3'h7) && mem != 2'h1) return 1'b1;
    return !p && ((mm == 4'h5) != (ss == 3'h2));
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    rnd = 16'h000F;
    {aresetn, field_start, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_wdata, s_axi_wstrb} = 36'h0;
    {sync_nonstandard, film_phase_flag, film_detected_flag} = 3'h0;
    {film_type_flag, global_motion_flag} = 2'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`SMS_OFF_EFF);
    check(rd, 32'h0027_1000);
    foreach (h[i]) begin
      axr(8'h48 + 8'(i == 3 ? 8 : i));
      check(rd, 32'h0);
    end
    axr(8'h40);
    check(rd, 32'h0);
    check(rr, 2'h2);
    axw(8'h44, 32'hFF, 4'hF);
    check(rr, 2'h2);
    axw(`SMS_OFF_MASTER, 32'hF, 4'h0);
    axr(`SMS_OFF_MASTER);
    check(rd, 32'h0);
    // Override sweep: every adaptive code with the nonstandard flag up, then vcr bit set.
    sync_nonstandard <= 1'b1;
    axw(`SMS_OFF_MASTER, 32'h3, 4'hF);
    axw(`SMS_OFF_SLAVE, 32'h1, 4'hF);
    for (int i = 0; i < 9; i++) begin
      ad = (i == 8) ? 3'h2 : 3'(i);
      if (i == 8) axw(`SMS_OFF_CTRL, 32'h8, 4'hF);
      axw(`SMS_OFF_ADAPT, {29'h0, ad}, 4'hF);
      field;
      check({effective_master_q, effective_slave_q}, eff(4'h3, 3'h1, ad, {i < 8, 4'h0}));
    end
    axr(`SMS_OFF_FLAGS);
    check(rd[4:0], 5'h0);
    repeat (80) begin
      rnd = lfsr(rnd);
      {ctrl, a, s, m} = rnd[13:0];
      axw(`SMS_OFF_MASTER, {28'h0, m}, 4'hF);
      axw(`SMS_OFF_ADAPT, {29'h0, a}, 4'hF);
      axw(`SMS_OFF_SLAVE, {29'h0, s}, 4'hF);
      axw(`SMS_OFF_CTRL, {28'h0, ctrl}, 4'hF);
      rnd = lfsr(rnd);
      f = {rnd[4] & rnd[5], rnd[3:0]};
      {sync_nonstandard, film_phase_flag, film_detected_flag, film_type_flag,
       global_motion_flag} <= f;
      f[4] = f[4] & !ctrl[3];
      @(posedge aclk);
      field;
      e = eff(m, s, a, f);
      check({effective_master_q, effective_slave_q}, e);
      check(line_pattern_q, pat(ctrl[0], e[2:0]));
      check(slave_mode_error_q, err(ctrl[0], ctrl[2:1], e[6:3], e[2:0]));
      axr(`SMS_OFF_FLAGS);
      check(rd[4:0], f);
      axr(`SMS_OFF_SLAVE);
      check(rd, {29'h0, s});
    end
    axw(`SMS_OFF_ADAPT, 32'h0, 4'hF);
    axw(`SMS_OFF_CTRL, 32'h0, 4'hF);
    lines(4'h0, 3'h4);
    check(h[0] + h[1], 1250);
    check(h[1] + h[2], 1250);
    rd = {22'h0, h[0]};
    lines(4'h0, 3'h6);
    check(h[0], rd);
    check(h[0] + h[1], 1250);
    lines(4'h5, 3'h2);
    check(h[0] + h[2], 1250);
    check(h[1] + h[3], 1250);
    check((h[0] == 10'd625) ^ (h[1] == 10'd625), 1);
    complete_run;
  end
endmodule // sms_scan_mode_selector_tb

bind sms_scan_mode_selector sms_scan_mode_selector_chk u_sms_scan_mode_selector_chk (.*);

`default_nettype wire
